// >>> shared/dram_host_pkg.sv
// Constants, timing counts and types for the DRAM host controller
package dram_host_pkg;

	localparam int CLK_PERIOD_NS = 50;

	localparam int ADDR_W = 16;
	localparam int HALF_W = 8;
	localparam int DATA_W = 4;
	localparam int ROW_MSB = 15;
	localparam int ROW_LSB = 8;
	localparam int COL_MSB = 7;
	localparam int COL_LSB = 0;
	localparam int WAIT_W = 4;
	localparam int AGE_W = 8;
	localparam int INIT_W = 4;
	localparam int POWER_W = 12;
	localparam int TICK_W = 9;

	// Pin timing, as printed
	localparam int ROW_PULSE_NS = 80;
	localparam int ROW_PULSE_MAX_NS = 10000;
	localparam int ROW_HOLD_NS = 15;
	localparam int PRECHARGE_NS = 75;
	localparam int COL_PULSE_NS = 30;
	localparam int COL_ACCESS_NS = 30;
	localparam int GATE_ACCESS_NS = 20;
	localparam int GATE_FLOAT_NS = 20;
	localparam int CBR_SETUP_NS = 10;
	localparam int COL_TO_STORE_NS = 60;
	localparam int ROW_TO_STORE_NS = 110;
	localparam int STORE_PULSE_NS = 15;
	localparam int POWER_UP_NS = 100000;
	localparam int REFRESH_WINDOW_NS = 4000000;
	localparam int ROW_COUNT = 256;
	localparam int REFRESH_TICK_NS = REFRESH_WINDOW_NS / ROW_COUNT;
	localparam int INIT_CYCLES = 8;

	// Least times round up, longest round down, never below one cycle
	function automatic int cyc_min(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int cyc_max(input int ns);
		int c;
		c = ns / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int max3(input int a, input int b, input int c);
		int m;
		m = (a > b) ? a : b;
		return (m > c) ? m : c;
	endfunction

	localparam logic [WAIT_W-1:0] ROW_PULSE_CYC = WAIT_W'(cyc_min(ROW_PULSE_NS));
	localparam logic [WAIT_W-1:0] ROW_HOLD_CYC = WAIT_W'(cyc_min(ROW_HOLD_NS));
	localparam logic [WAIT_W-1:0] PRECHARGE_CYC = WAIT_W'(cyc_min(PRECHARGE_NS));
	localparam logic [WAIT_W-1:0] ACCESS_CYC =
		WAIT_W'(cyc_min(max3(COL_PULSE_NS, COL_ACCESS_NS, GATE_ACCESS_NS)));
	localparam logic [WAIT_W-1:0] GATE_FLOAT_CYC = WAIT_W'(cyc_min(GATE_FLOAT_NS));
	localparam logic [WAIT_W-1:0] CBR_SETUP_CYC = WAIT_W'(cyc_min(CBR_SETUP_NS));
	localparam logic [WAIT_W-1:0] STORE_PULSE_CYC = WAIT_W'(cyc_min(STORE_PULSE_NS));
	localparam logic [WAIT_W-1:0] ONE_CYC = WAIT_W'(1);
	localparam logic [WAIT_W-1:0] PAGE_LINGER_CYC = WAIT_W'(4);
	localparam logic [AGE_W-1:0] COL_TO_STORE_CYC = AGE_W'(cyc_min(COL_TO_STORE_NS));
	localparam logic [AGE_W-1:0] ROW_TO_STORE_CYC = AGE_W'(cyc_min(ROW_TO_STORE_NS));
	localparam logic [AGE_W-1:0] ROW_PULSE_MAX_CYC = AGE_W'(cyc_max(ROW_PULSE_MAX_NS));
	localparam logic [AGE_W-1:0] PAGE_GUARD_CYC = AGE_W'(16);
	localparam logic [POWER_W-1:0] POWER_UP_CYC = POWER_W'(cyc_min(POWER_UP_NS));
	localparam logic [TICK_W-1:0] REFRESH_TICK_CYC = TICK_W'(cyc_max(REFRESH_TICK_NS));
	localparam logic [INIT_W-1:0] INIT_COUNT = INIT_W'(INIT_CYCLES);

	typedef enum logic [1:0] {
		OP_READ = 2'h0,
		OP_WRITE = 2'h1,
		OP_RMW = 2'h2
	} op_t;

	typedef enum logic [3:0] {
		ST_INIT_WAIT = 4'h0,
		ST_IDLE = 4'h1,
		ST_ROW_SETUP = 4'h2,
		ST_ROW = 4'h3,
		ST_COL = 4'h4,
		ST_ACCESS = 4'h5,
		ST_RMW_GATE = 4'h6,
		ST_RMW_STORE = 4'h7,
		ST_PAGE = 4'h8,
		ST_HIDE_UP = 4'h9,
		ST_HIDE_ROW = 4'hA,
		ST_REF_SETUP = 4'hB,
		ST_REF_ROW = 4'hC,
		ST_PRECHARGE = 4'hD
	} state_t;

endpackage

// >>> shared/refresh_if.sv
// Refresh request and acknowledge between scheduler and sequencer
interface refresh_if;
	logic due;
	logic ack;
	logic powerUpDone;

	modport scheduler (output due, output powerUpDone, input ack);
	modport sequencer (input due, input powerUpDone, output ack);
endinterface

// >>> verilog/refresh_scheduler.sv
// Power-up pause and periodic refresh request timer
module refresh_scheduler
	import dram_host_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	refresh_if.scheduler sched
);

	logic [POWER_W-1:0] powerCnt;
	logic [TICK_W-1:0] tickCnt;
	logic powerDone;
	logic due;

	wire tick = powerDone && (tickCnt == REFRESH_TICK_CYC - TICK_W'(1));

	// Pause after power-up before any strobe moves
	always_ff @(posedge mclk) begin
		if (rst) begin
			powerCnt <= '0;
			powerDone <= 1'b0;
		end else if (!powerDone) begin
			powerCnt <= powerCnt + POWER_W'(1);
			powerDone <= (powerCnt == POWER_UP_CYC - POWER_W'(1));
		end
	end

	// One request per row slot keeps all rows inside the window; set beats ack
	always_ff @(posedge mclk) begin
		if (rst) begin
			tickCnt <= '0;
			due <= 1'b0;
		end else begin
			tickCnt <= (tick || !powerDone) ? '0 : tickCnt + TICK_W'(1);
			due <= tick || (due && !sched.ack);
		end
	end

	assign sched.due = due;
	assign sched.powerUpDone = powerDone;

endmodule

// >>> verilog/dram_host_ctrl.sv
// Host-side sequencer driving a 64K x 4 page-mode DRAM over its pins
module dram_host_ctrl
	import dram_host_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic reqValid,
	input wire logic [1:0] reqOp,
	input wire logic [ADDR_W-1:0] reqAddr,
	input wire logic [DATA_W-1:0] reqWdata,
	input wire logic refreshRasOnly,
	output logic reqTaken,
	output logic [DATA_W-1:0] rdData,
	output logic rdValid,
	output logic initDone,
	output logic rowStrobeN,
	output logic colStrobeN,
	output logic storeStrobeN,
	output logic driveGateN,
	output logic [HALF_W-1:0] muxAddressPins,
	output logic [DATA_W-1:0] sharedDataOut,
	output logic sharedDataOe,
	input wire logic [DATA_W-1:0] sharedDataIn
);

	state_t state, next_state;
	op_t op, next_op;
	logic [WAIT_W-1:0] waitCnt, next_waitCnt;
	logic [HALF_W-1:0] rowAddr, colAddr, refRow;
	logic [DATA_W-1:0] wdata;
	logic [AGE_W-1:0] rasAge, casAge;
	logic [INIT_W-1:0] initLeft;
	logic rasOnlyMode;

	refresh_if rif();

	// Timer owns the due flag; this sequencer answers on ack
	refresh_scheduler refresh_scheduler_i (
		.mclk(mclk),
		.rst(rst),
		.sched(rif.scheduler)
	);

	// Saturating age of a strobe that is held low
	function automatic logic [AGE_W-1:0] bump(input logic [AGE_W-1:0] age);
		return (age == '1) ? age : age + AGE_W'(1);
	endfunction

	// Cycles each state lasts at least, except ST_PAGE, which lasts at most this long
	function automatic logic [WAIT_W-1:0] stay(input state_t s);
		case (s)
			ST_ROW: return ROW_HOLD_CYC;
			ST_ACCESS: return ACCESS_CYC;
			ST_RMW_GATE: return GATE_FLOAT_CYC;
			ST_RMW_STORE: return STORE_PULSE_CYC;
			ST_PAGE: return PAGE_LINGER_CYC;
			ST_HIDE_UP: return PRECHARGE_CYC;
			ST_HIDE_ROW: return ROW_PULSE_CYC;
			ST_REF_SETUP: return CBR_SETUP_CYC;
			ST_REF_ROW: return ROW_PULSE_CYC;
			ST_PRECHARGE: return PRECHARGE_CYC;
			default: return ONE_CYC;
		endcase
	endfunction

	// Request and refresh decisions
	wire waitDone = (waitCnt == '0);
	wire refreshWanted = rif.due || (rif.powerUpDone && initLeft != '0);
	wire sameRow = (reqAddr[ROW_MSB:ROW_LSB] == rowAddr);
	wire pageOk = (rasAge < ROW_PULSE_MAX_CYC - PAGE_GUARD_CYC);
	wire takeIdle = (state == ST_IDLE) && initDone && !refreshWanted && reqValid;
	wire takePage = (state == ST_PAGE) && reqValid && sameRow && !refreshWanted && pageOk;
	wire take = takeIdle || takePage;
	wire isRead = (op != OP_WRITE);
	wire readDone = (state == ST_ACCESS) && waitDone && isRead;
	wire hideNow = (op == OP_READ) && rif.due && !refreshRasOnly;
	wire storeTimingMet = (casAge >= COL_TO_STORE_CYC - AGE_W'(1)) &&
		(rasAge >= ROW_TO_STORE_CYC - AGE_W'(1));
	wire refDone = ((state == ST_REF_ROW) || (state == ST_HIDE_ROW)) && waitDone;
	wire pageLeave = waitDone || refreshWanted || (reqValid && !sameRow) || !pageOk;

	// Sequencer; every access path closes through precharge
	always_comb begin
		next_state = state;
		case (state)
			ST_INIT_WAIT: if (rif.powerUpDone) next_state = ST_IDLE;
			ST_IDLE: begin
				if (rif.powerUpDone && refreshWanted) next_state = ST_REF_SETUP;
				else if (takeIdle) next_state = ST_ROW_SETUP;
			end
			ST_ROW_SETUP: next_state = ST_ROW;
			ST_ROW: if (waitDone) next_state = ST_COL;
			ST_COL: next_state = ST_ACCESS;
			ST_ACCESS: begin
				if (waitDone) begin
					if (op == OP_RMW) next_state = ST_RMW_GATE;
					else if (hideNow) next_state = ST_HIDE_UP;
					else next_state = ST_PAGE;
				end
			end
			ST_RMW_GATE: if (waitDone && storeTimingMet) next_state = ST_RMW_STORE;
			ST_RMW_STORE: if (waitDone) next_state = ST_PAGE;
			ST_PAGE: begin
				if (takePage) next_state = ST_COL;
				else if (pageLeave) next_state = ST_PRECHARGE;
			end
			ST_HIDE_UP: if (waitDone) next_state = ST_HIDE_ROW;
			ST_HIDE_ROW: if (waitDone) next_state = ST_PRECHARGE;
			ST_REF_SETUP: if (waitDone) next_state = ST_REF_ROW;
			ST_REF_ROW: if (waitDone) next_state = ST_PRECHARGE;
			ST_PRECHARGE: if (waitDone) next_state = ST_IDLE;
			default: next_state = ST_INIT_WAIT;
		endcase
	end

	// Latched request fields, replaced only when a request is taken; the refresh mode follows its input in every idle cycle
	wire [HALF_W-1:0] next_rowAddr = take ? reqAddr[ROW_MSB:ROW_LSB] : rowAddr;
	wire [HALF_W-1:0] next_colAddr = take ? reqAddr[COL_MSB:COL_LSB] : colAddr;
	wire [DATA_W-1:0] next_wdata = take ? reqWdata : wdata;
	wire next_rasOnly = (state == ST_IDLE) ? refreshRasOnly : rasOnlyMode;
	assign next_op = take ? op_t'(reqOp) : op;
	assign next_waitCnt = (next_state != state) ? stay(next_state) - ONE_CYC :
		(waitDone ? '0 : waitCnt - ONE_CYC);

	// Pin values decoded from the coming state so the pins are plain flops
	wire colPhase = next_state inside {ST_COL, ST_ACCESS, ST_RMW_GATE, ST_RMW_STORE};
	wire refPhase = next_state inside {ST_REF_SETUP, ST_REF_ROW};
	wire earlyWrite = (next_op == OP_WRITE) && (next_state inside {ST_COL, ST_ACCESS});
	wire next_rowStrobeN = !(next_state inside {ST_ROW, ST_COL, ST_ACCESS, ST_RMW_GATE,
		ST_RMW_STORE, ST_PAGE, ST_HIDE_ROW, ST_REF_ROW});
	wire next_colStrobeN = !((next_state inside {ST_ACCESS, ST_RMW_GATE, ST_RMW_STORE,
		ST_HIDE_UP, ST_HIDE_ROW}) || (refPhase && !next_rasOnly));
	wire next_storeStrobeN = !(earlyWrite || next_state == ST_RMW_STORE);
	wire next_driveGateN = !(((next_op != OP_WRITE) && next_state == ST_ACCESS) ||
		(next_state inside {ST_HIDE_UP, ST_HIDE_ROW}));
	wire next_dataOe = earlyWrite || (next_state == ST_RMW_STORE);
	wire [HALF_W-1:0] next_mux = colPhase ? next_colAddr :
		((refPhase && next_rasOnly) ? refRow : next_rowAddr);

	// State, wait count and request latch
	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= ST_INIT_WAIT;
			waitCnt <= '0;
			op <= OP_READ;
			rowAddr <= '0;
			colAddr <= '0;
			wdata <= '0;
			rasOnlyMode <= 1'b0;
		end else begin
			state <= next_state;
			waitCnt <= next_waitCnt;
			op <= next_op;
			rowAddr <= next_rowAddr;
			colAddr <= next_colAddr;
			wdata <= next_wdata;
			rasOnlyMode <= next_rasOnly;
		end
	end

	// Strobe ages drive the read-modify-write and page limits
	always_ff @(posedge mclk) begin
		if (rst) begin
			rasAge <= '0;
			casAge <= '0;
		end else begin
			rasAge <= rowStrobeN ? '0 : bump(rasAge);
			casAge <= colStrobeN ? '0 : bump(casAge);
		end
	end

	// Row-only refresh walks all rows; eight strobe cycles before first use
	always_ff @(posedge mclk) begin
		if (rst) begin
			refRow <= '0;
			initLeft <= INIT_COUNT;
			initDone <= 1'b0;
		end else begin
			if (refDone && rasOnlyMode && state == ST_REF_ROW)
				refRow <= refRow + HALF_W'(1);
			if (refDone && initLeft != '0)
				initLeft <= initLeft - INIT_W'(1);
			initDone <= rif.powerUpDone && (initLeft == '0);
		end
	end

	assign rif.ack = refDone;

	// Pins and user answers, all registered
	always_ff @(posedge mclk) begin
		if (rst) begin
			rowStrobeN <= 1'b1;
			colStrobeN <= 1'b1;
			storeStrobeN <= 1'b1;
			driveGateN <= 1'b1;
			muxAddressPins <= '0;
			sharedDataOut <= '0;
			sharedDataOe <= 1'b0;
			reqTaken <= 1'b0;
			rdValid <= 1'b0;
			rdData <= '0;
		end else begin
			rowStrobeN <= next_rowStrobeN;
			colStrobeN <= next_colStrobeN;
			storeStrobeN <= next_storeStrobeN;
			driveGateN <= next_driveGateN;
			muxAddressPins <= next_mux;
			sharedDataOut <= next_wdata;
			sharedDataOe <= next_dataOe;
			reqTaken <= take;
			rdValid <= readDone;
			if (readDone) rdData <= sharedDataIn;
		end
	end

endmodule

// >>> verif/dram_model.sv
// Behavioural model of the 64K x 4 page-mode dynamic RAM
module dram_model (
	input wire logic rowStrobeN,
	input wire logic colStrobeN,
	input wire logic storeStrobeN,
	input wire logic driveGateN,
	input wire logic [7:0] muxAddressPins,
	input wire logic [3:0] dq,
	output logic [3:0] devOut,
	output logic devOe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] mem [0:65535];
	logic [7:0] row = 8'h00;
	logic [7:0] rowCount = 8'h00;
	logic [15:0] word = 16'h0000;
	logic [3:0] rd = 4'h0;
	logic hold = 1'b0;
	logic ready = 1'b0;
	initial foreach (mem[k]) mem[k] = 4'h0;
	// Row latch, or a counter step when the column strobe came first
	always @(negedge rowStrobeN) begin
		if (colStrobeN) row = muxAddressPins;
		else rowCount = rowCount + 8'h01;
	end
	// Column latch picks early write or read
	always @(negedge colStrobeN) if (!rowStrobeN) begin
		word = {row, muxAddressPins};
		if (!storeStrobeN) mem[word] = dq;
		else begin
			rd = mem[word];
			hold = 1'b1;
			// Lines stay wrong until the column access time has run, so early sampling fails
			ready = 1'b0;
			ready <= #(dram_host_pkg::COL_ACCESS_NS) 1'b1;
		end
	end
	// Late store: wait a step so the data drivers settle first
	always @(negedge storeStrobeN) begin
		#1;
		if (!colStrobeN && hold) mem[word] = dq;
	end
	always @(posedge colStrobeN) begin
		hold = 1'b0;
		ready = 1'b0;
	end
	// Floats with the column strobe or the gate high; released lines show inverted data
	assign devOe = hold && ready && !colStrobeN && !driveGateN;
	assign devOut = devOe ? rd : ~rd;
endmodule

// >>> verif/dram_host_ctrl_chk.sv
// Pin protocol assertions for the DRAM host controller
module dram_host_ctrl_chk (
	input wire logic mclk,
	input wire logic rst,
	input wire logic rdValid,
	input wire logic rowStrobeN,
	input wire logic colStrobeN,
	input wire logic storeStrobeN,
	input wire logic driveGateN,
	input wire logic sharedDataOe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_reset_quiet: assert property (disable iff (1'b0) rst |=> rowStrobeN && colStrobeN
		&& storeStrobeN && driveGateN && !sharedDataOe) else $error("strobe active in reset");
	a_row_pulse: assert property ($fell(rowStrobeN) |=> !rowStrobeN)
		else $error("row pulse short");
	a_row_precharge: assert property ($rose(rowStrobeN) |=> rowStrobeN)
		else $error("precharge short");
	a_col_after_row: assert property ($fell(colStrobeN) && !rowStrobeN |-> !$past(rowStrobeN))
		else $error("column before row");
	a_gate_needs_col: assert property (!driveGateN |-> !colStrobeN)
		else $error("gate without column");
	a_no_contention: assert property (sharedDataOe |-> driveGateN)
		else $error("bus contention");
	a_store_data: assert property (!storeStrobeN |-> sharedDataOe)
		else $error("store without data");
	a_early_write: assert property ($fell(storeStrobeN) && colStrobeN |-> !rowStrobeN ##1 !colStrobeN)
		else $error("early write order");
	a_cbr_setup: assert property ($fell(rowStrobeN) && !colStrobeN |-> !$past(colStrobeN))
		else $error("refresh setup short");
	a_rmw_delay: assert property ($fell(storeStrobeN) && !colStrobeN
		|-> driveGateN && !$past(colStrobeN, 2) && !$past(rowStrobeN, 3)) else $error("rmw delay");
	c_read: cover property (rdValid);
	c_hidden: cover property ($fell(rowStrobeN) && !colStrobeN && !driveGateN);
	c_cbr: cover property ($fell(rowStrobeN) && !colStrobeN);
	c_rmw: cover property ($fell(storeStrobeN) && !colStrobeN);
endmodule
bind dram_host_ctrl dram_host_ctrl_chk chk_i (.mclk(mclk), .rst(rst), .rdValid(rdValid),
	.rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN), .storeStrobeN(storeStrobeN),
	.driveGateN(driveGateN), .sharedDataOe(sharedDataOe));

// >>> verif/test_fast_page_dram_x4_core.sv
// Self-checking bench: host controller against the device model
module test_fast_page_dram_x4_core
	import dram_host_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic reqValid = 1'b0;
	logic [1:0] reqOp = 2'h0;
	logic [15:0] reqAddr = 16'h0000;
	logic [3:0] reqWdata = 4'h0;
	logic refreshRasOnly = 1'b0;
	logic reqTaken, rdValid, initDone, rowStrobeN, colStrobeN, storeStrobeN, driveGateN;
	logic sharedDataOe, devOe;
	logic [3:0] rdData, sharedDataOut, devOut;
	logic [7:0] muxAddressPins;
	wire [3:0] dq;
	logic [3:0] refMem [logic [15:0]];
	logic [3:0] exp [$];
	int n_mismatch = 0;
	int samples_checked = 0;
	int rowFalls = 0;
	always #25 mclk = ~mclk;
	// Wire level: the controller drives when it enables, the device output otherwise
	assign dq = sharedDataOe ? sharedDataOut : devOut;
	dram_host_ctrl dram_host_ctrl_i (.mclk(mclk), .rst(rst), .reqValid(reqValid), .reqOp(reqOp),
		.reqAddr(reqAddr), .reqWdata(reqWdata), .refreshRasOnly(refreshRasOnly),
		.reqTaken(reqTaken), .rdData(rdData), .rdValid(rdValid), .initDone(initDone),
		.rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN), .storeStrobeN(storeStrobeN),
		.driveGateN(driveGateN), .muxAddressPins(muxAddressPins),
		.sharedDataOut(sharedDataOut), .sharedDataOe(sharedDataOe), .sharedDataIn(dq));
	dram_model dram_model_i (.rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN),
		.storeStrobeN(storeStrobeN), .driveGateN(driveGateN), .muxAddressPins(muxAddressPins),
		.dq(dq), .devOut(devOut), .devOe(devOe));
	always @(negedge rowStrobeN) if (initDone !== 1'b1) rowFalls++;
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic give_up(input string what);
		n_mismatch++;
		$display("wrong value %s expected done seen timeout", what);
		end_of_test();
	endtask
	// Hold the request until taken; a read notes the word it should return
	task automatic op(input op_t o, input logic [15:0] a, input logic [3:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		reqValid <= 1'b1;
		reqOp <= o;
		reqAddr <= a;
		reqWdata <= d;
		if (o != OP_WRITE) exp.push_back(refMem.exists(a) ? refMem[a] : 4'h0);
		if (o != OP_READ) refMem[a] = d;
		do begin
			@(posedge mclk);
			n++;
		end while (reqTaken !== 1'b1 && n < 3000);
		if (n >= 3000) give_up("reqTaken");
		reqValid <= 1'b0;
	endtask
	// Each returned word against the oldest note
	always @(posedge mclk) if (rdValid === 1'b1) begin
		samples_checked++;
		if (exp.size() == 0) exp.push_back(4'hX);
		if (rdData !== exp[0]) begin
			n_mismatch++;
			$display("wrong value rdData expected %h seen %h", exp[0], rdData);
		end
		void'(exp.pop_front());
	end
	initial begin
		logic [15:0] a;
		int n;
		void'($urandom(32'h6491FAC1));
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		n = 0;
		while (initDone !== 1'b1 && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 3000) give_up("initDone");
		samples_checked++;
		if (n < 2000 || rowFalls !== 8) begin
			n_mismatch++;
			$display("wrong value initRows expected 8 seen %0d", rowFalls);
		end
		$display("init test done");
		// Mixed traffic, then same-row reads that stay in the open page
		for (int t = 0; t < 2; t++) begin
			refreshRasOnly <= t[0];
			for (int i = 0; i < 60; i++) begin
				a = 16'($urandom);
				op(op_t'($urandom_range(2)), a, 4'($urandom));
				op(OP_READ, a, 4'h0);
				op(OP_READ, {a[15:8], 8'($urandom)}, 4'h0);
			end
			$display("traffic test %0d done", t);
		end
		n = 0;
		while (exp.size() != 0 && n < 100) begin
			@(posedge mclk);
			n++;
		end
		if (exp.size() != 0) give_up("rdValid");
		end_of_test();
	end
endmodule
